// ===== rtl/adcsel_pkg.sv
package adcsel_pkg;
	////////////////////////////////////////////////////////////////////////
	// register pages and addresses
	localparam logic [7:0] PAGE_MAIN = 8'h00;
	localparam logic [7:0] PAGE_CAL = 8'h0f;
	localparam logic [7:0] ADDR_CHSEL = 8'hbb;
	localparam logic [7:0] ADDR_FACTORY_TEMP_OFFSET_LO = 8'hbd;
	localparam logic [7:0] ADDR_FACTORY_TEMP_OFFSET_HI = 8'hbe;
	localparam logic [7:0] ADDR_REFCTL = 8'hd1;
	////////////////////////////////////////////////////////////////////////
	// field layouts and reset values
	localparam int CHSEL_W = 5;
	localparam logic [4:0] CHSEL_RESET = 5'h1f;
	localparam int REFGND_BIT = 5;
	localparam int VREF_LSB = 3;
	localparam int TEMP_ON_BIT = 2;
	localparam logic [7:0] REFCTL_RESET = 8'h18;
	localparam int FACTORY_TEMP_OFFSET_W = 10;
	localparam int FACTORY_TEMP_OFFSET_HI_LSB = 2;
	localparam int FACTORY_TEMP_OFFSET_LO_POS = 6;
	////////////////////////////////////////////////////////////////////////
	// positive input codes
	localparam logic [4:0] CODE_P0_LAST = 5'h07;
	localparam logic [4:0] CODE_P1_FIRST = 5'h0c;
	localparam logic [4:0] CODE_P1_LAST = 5'h0f;
	localparam logic [4:0] CODE_P2_FIRST = 5'h10;
	localparam logic [4:0] CODE_P2_LAST = 5'h13;
	localparam logic [4:0] CODE_TEMP = 5'h1b;
	localparam logic [4:0] CODE_VBAT_A = 5'h1c;
	localparam logic [4:0] CODE_VREG = 5'h1d;
	localparam logic [4:0] CODE_VBAT_B = 5'h1e;
	localparam logic [4:0] CODE_GND = 5'h1f;
	localparam logic [1:0] PORT0 = 2'h0;
	localparam logic [1:0] PORT1 = 2'h1;
	localparam logic [1:0] PORT2 = 2'h2;
	////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [2:0] {
		SRC_NONE = 3'h0,
		SRC_PORT = 3'h1,
		SRC_TEMP = 3'h2,
		SRC_VBAT = 3'h3,
		SRC_VREG = 3'h4,
		SRC_GND = 3'h5
	} adcsel_src_e;
	typedef enum logic [1:0] {
		VREF_EXT_PIN = 2'h0,
		VREF_MAIN_SUPPLY = 2'h1,
		VREF_CORE_REG = 2'h2,
		VREF_INT_HS = 2'h3
	} adcsel_vref_e;
	typedef struct packed {
		logic [7:0] page;
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} adcsel_sfr_req_s;
	typedef struct packed {
		logic [4:0] positive_input_code;
		adcsel_src_e src;
		logic [1:0] port;
		logic [2:0] pin;
		logic temp_route;
		logic temp_sensor_on;
		logic temp_hiz;
		logic temp_data_valid;
		adcsel_vref_e vref;
		logic analog_ground_pin_sel;
		logic analog_ground_pin_effective;
	} adcsel_ana_s;
endpackage

// ===== rtl/adcsel_ctl.sv
`timescale 1ns/1ps
module adcsel_ctl (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire adcsel_pkg::adcsel_sfr_req_s i_sfr,
	input wire logic [adcsel_pkg::FACTORY_TEMP_OFFSET_W-1:0] i_factory_temp_offset,
	output logic [7:0] o_sfr_rdata,
	output logic o_sfr_rvalid,
	output adcsel_pkg::adcsel_ana_s o_ana
);
	import adcsel_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// decode of the positive input code
	function automatic adcsel_ana_s decode_code(input logic [4:0] code,
		input logic [7:0] refctl);
		adcsel_ana_s a;
		a = '0;
		a.positive_input_code = code;
		a.src = SRC_NONE;
		a.port = PORT0;
		a.pin = 3'h0;
		if (code <= CODE_P0_LAST) begin
			a.src = SRC_PORT;
			a.port = PORT0;
			a.pin = code[2:0];
		end else if (code >= CODE_P1_FIRST && code <= CODE_P1_LAST) begin
			a.src = SRC_PORT;
			a.port = PORT1;
			a.pin = {1'b1, code[1:0]};
		end else if (code >= CODE_P2_FIRST && code <= CODE_P2_LAST) begin
			a.src = SRC_PORT;
			a.port = PORT2;
			a.pin = {1'b0, code[1:0]};
		end else begin
			unique case (code)
				CODE_TEMP: a.src = SRC_TEMP;
				CODE_VBAT_A, CODE_VBAT_B: a.src = SRC_VBAT;
				CODE_VREG: a.src = SRC_VREG;
				CODE_GND: a.src = SRC_GND;
				default: a.src = SRC_NONE;
			endcase
		end
		a.temp_sensor_on = refctl[TEMP_ON_BIT];
		a.temp_route = (code == CODE_TEMP);
		a.temp_hiz = !refctl[TEMP_ON_BIT];
		a.temp_data_valid = a.temp_route && refctl[TEMP_ON_BIT];
		a.vref = adcsel_vref_e'(refctl[VREF_LSB+1:VREF_LSB]);
		a.analog_ground_pin_sel = refctl[REFGND_BIT];
		// the sensor is always sampled against chip ground
		a.analog_ground_pin_effective = refctl[REFGND_BIT] && !a.temp_route;
		return a;
	endfunction

	function automatic logic hit(input adcsel_sfr_req_s r,
		input logic [7:0] page, input logic [7:0] addr);
		return (r.page == page) && (r.addr == addr);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// registers
	logic [4:0] chsel_reg;
	logic [4:0] chsel_next;
	logic [7:0] refctl_reg;
	logic [7:0] refctl_next;
	logic [FACTORY_TEMP_OFFSET_W-1:0] factory_temp_offset_reg;
	logic [FACTORY_TEMP_OFFSET_W-1:0] factory_temp_offset_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic rvalid_reg;
	logic rvalid_next;
	adcsel_ana_s ana_reg;
	adcsel_ana_s ana_next;

	always_comb begin
		chsel_next = chsel_reg;
		refctl_next = refctl_reg;
		factory_temp_offset_next = factory_temp_offset_reg;
		if (i_sfr.wr && hit(i_sfr, PAGE_MAIN, ADDR_CHSEL)) begin
			chsel_next = i_sfr.wdata[CHSEL_W-1:0];
		end
		if (i_sfr.wr && hit(i_sfr, PAGE_MAIN, ADDR_REFCTL)) begin
			refctl_next = {2'b00, i_sfr.wdata[5:2], 2'b00};
		end
	end

	always_comb begin
		rvalid_next = i_sfr.rd;
		rdata_next = 8'h00;
		if (i_sfr.rd) begin
			if (hit(i_sfr, PAGE_MAIN, ADDR_CHSEL)) begin
				rdata_next = {3'b000, chsel_reg};
			end else if (hit(i_sfr, PAGE_MAIN, ADDR_REFCTL)) begin
				rdata_next = refctl_reg;
			end else if (hit(i_sfr, PAGE_CAL, ADDR_FACTORY_TEMP_OFFSET_HI)) begin
				rdata_next = factory_temp_offset_reg[FACTORY_TEMP_OFFSET_W-1:FACTORY_TEMP_OFFSET_HI_LSB];
			end else if (hit(i_sfr, PAGE_CAL, ADDR_FACTORY_TEMP_OFFSET_LO)) begin
				rdata_next = {factory_temp_offset_reg[FACTORY_TEMP_OFFSET_HI_LSB-1:0], 6'h00};
			end
		end
	end

	always_comb begin
		ana_next = decode_code(chsel_next, refctl_next);
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			chsel_reg <= CHSEL_RESET;
			refctl_reg <= REFCTL_RESET;
			factory_temp_offset_reg <= i_factory_temp_offset;
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
			ana_reg <= decode_code(CHSEL_RESET, REFCTL_RESET);
		end else begin
			chsel_reg <= chsel_next;
			refctl_reg <= refctl_next;
			factory_temp_offset_reg <= factory_temp_offset_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
			ana_reg <= ana_next;
		end
	end

	assign o_sfr_rdata = rdata_reg;
	assign o_sfr_rvalid = rvalid_reg;
	assign o_ana = ana_reg;

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_chsel_wr;
		i_sfr.wr && i_sfr.page == PAGE_MAIN && i_sfr.addr == ADDR_CHSEL;
	endsequence

	sequence s_chsel_rd;
		i_sfr.rd && i_sfr.page == PAGE_MAIN && i_sfr.addr == ADDR_CHSEL;
	endsequence

	AST_CHSEL_WRITE: assert property (@(posedge i_core_clk) disable iff (i_rst)
		s_chsel_wr |=> o_ana.positive_input_code ==
		$past(i_sfr.wdata[4:0]))
		else $error("input code not taken from write");

	AST_CHSEL_READBACK: assert property (@(posedge i_core_clk)
		disable iff (i_rst)
		s_chsel_wr ##1 (s_chsel_rd and !i_sfr.wr) |=>
		o_sfr_rvalid && o_sfr_rdata == {3'b000, $past(i_sfr.wdata[4:0], 2)})
		else $error("input select readback wrong");

	AST_RESET_CODE: assert property (@(posedge i_core_clk)
		$past(i_rst) |-> o_ana.positive_input_code == 5'h1f &&
		o_ana.src == SRC_GND)
		else $error("input code reset wrong");

	AST_PORT_MAP: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_ana.positive_input_code >= 5'h0c &&
		o_ana.positive_input_code <= 5'h0f |->
		o_ana.src == SRC_PORT && o_ana.port == 2'h1 &&
		o_ana.pin[2])
		else $error("port 1 mapping wrong");

	AST_SPECIAL_CODES: assert property (@(posedge i_core_clk)
		disable iff (i_rst)
		(o_ana.positive_input_code == 5'h1e |-> o_ana.src == SRC_VBAT) and
		(o_ana.positive_input_code == 5'h1d |-> o_ana.src == SRC_VREG) and
		(o_ana.positive_input_code == 5'h0a |-> o_ana.src == SRC_NONE))
		else $error("special code decode wrong");

	AST_TEMP_ROUTE: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_ana.temp_route == (o_ana.src == SRC_TEMP))
		else $error("sensor routed without its code");

	AST_TEMP_HIZ: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!o_ana.temp_sensor_on |-> o_ana.temp_hiz && !o_ana.temp_data_valid)
		else $error("disabled sensor not high impedance");

	AST_FACTORY_TEMP_OFFSET_HI: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_sfr.rd && i_sfr.page == PAGE_CAL && i_sfr.addr == ADDR_FACTORY_TEMP_OFFSET_HI |=>
		o_sfr_rdata == factory_temp_offset_reg[9:2])
		else $error("offset high byte wrong");

	AST_FACTORY_TEMP_OFFSET_LO: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_sfr.rd && i_sfr.page == PAGE_CAL && i_sfr.addr == ADDR_FACTORY_TEMP_OFFSET_LO |=>
		o_sfr_rdata[5:0] == 6'h00 && o_sfr_rdata[7:6] == factory_temp_offset_reg[1:0])
		else $error("offset low byte wrong");

	AST_FACTORY_TEMP_OFFSET_STABLE: assert property (@(posedge i_core_clk)
		disable iff (i_rst)
		!$past(i_rst) |-> $stable(factory_temp_offset_reg))
		else $error("offset changed after reset");

	AST_VREF_FIELD: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_sfr.wr && i_sfr.page == PAGE_MAIN && i_sfr.addr == ADDR_REFCTL |=>
		o_ana.vref == adcsel_vref_e'($past(i_sfr.wdata[4:3])) &&
		o_ana.analog_ground_pin_sel == $past(i_sfr.wdata[5]))
		else $error("reference selection not taken");

	AST_PORT0_MAP: assert property (@(posedge i_core_clk)
		disable iff (i_rst) o_ana.positive_input_code <= CODE_P0_LAST |->
		o_ana.src == SRC_PORT && o_ana.port == PORT0 &&
		o_ana.pin == o_ana.positive_input_code[2:0])
		else $error("port 0 mapping wrong");

	AST_PORT2_MAP: assert property (@(posedge i_core_clk)
		disable iff (i_rst) o_ana.positive_input_code >= CODE_P2_FIRST &&
		o_ana.positive_input_code <= CODE_P2_LAST |->
		o_ana.src == SRC_PORT && o_ana.port == PORT2 && !o_ana.pin[2])
		else $error("port 2 mapping wrong");

	AST_TEMP_CODE: assert property (@(posedge i_core_clk)
		disable iff (i_rst)
		o_ana.positive_input_code == CODE_TEMP |-> o_ana.src == SRC_TEMP)
		else $error("sensor code decode wrong");

	AST_VBAT_A_CODE: assert property (@(posedge i_core_clk)
		disable iff (i_rst)
		o_ana.positive_input_code == CODE_VBAT_A |-> o_ana.src == SRC_VBAT)
		else $error("battery code decode wrong");

	AST_GND_CODE: assert property (@(posedge i_core_clk)
		disable iff (i_rst)
		o_ana.positive_input_code == CODE_GND |-> o_ana.src == SRC_GND)
		else $error("ground code decode wrong");

	AST_RESERVED_CODE: assert property (@(posedge i_core_clk)
		disable iff (i_rst) (o_ana.positive_input_code inside {[5'h08:5'h0b],
		[5'h14:5'h1a]}) |-> o_ana.src == SRC_NONE)
		else $error("reserved code not decoded as none");

	AST_TEMP_VALID: assert property (@(posedge i_core_clk)
		disable iff (i_rst) o_ana.temp_data_valid ==
		(o_ana.temp_route && o_ana.temp_sensor_on))
		else $error("sensor data valid wrong");

	AST_TEMP_ON: assert property (@(posedge i_core_clk)
		disable iff (i_rst) i_sfr.wr && i_sfr.page == PAGE_MAIN &&
		i_sfr.addr == ADDR_REFCTL |=>
		o_ana.temp_sensor_on == $past(i_sfr.wdata[2]))
		else $error("sensor enable not taken");

	AST_RVALID_PULSE: assert property (@(posedge i_core_clk)
		disable iff (i_rst) o_sfr_rvalid == $past(i_sfr.rd))
		else $error("read valid not one cycle after read");

	AST_UNMAPPED_READ: assert property (@(posedge i_core_clk)
		disable iff (i_rst) i_sfr.rd && i_sfr.page == PAGE_CAL &&
		i_sfr.addr == ADDR_CHSEL |=> o_sfr_rdata == 8'h00)
		else $error("unmapped read not zero");

	AST_REFCTL_READ: assert property (@(posedge i_core_clk)
		disable iff (i_rst) i_sfr.rd && i_sfr.page == PAGE_MAIN &&
		i_sfr.addr == ADDR_REFCTL |=>
		o_sfr_rdata[7:6] == 2'h0 && o_sfr_rdata[1:0] == 2'h0)
		else $error("reference control unused bits not zero");

	AST_ANALOG_GROUND_PIN_EFF: assert property (@(posedge i_core_clk)
		disable iff (i_rst) o_ana.analog_ground_pin_effective ==
		(o_ana.analog_ground_pin_sel && !o_ana.temp_route))
		else $error("effective ground selection wrong");

	AST_CHSEL_HOLD: assert property (@(posedge i_core_clk)
		disable iff (i_rst) !(i_sfr.wr && i_sfr.page == PAGE_MAIN &&
		i_sfr.addr == ADDR_CHSEL) |=> $stable(o_ana.positive_input_code))
		else $error("input code changed without write");

	AST_FACTORY_TEMP_OFFSET_NO_WRITE: assert property (@(posedge i_core_clk)
		disable iff (i_rst) i_sfr.wr && i_sfr.page == PAGE_CAL &&
		i_sfr.addr == ADDR_FACTORY_TEMP_OFFSET_HI |=> $stable(factory_temp_offset_reg))
		else $error("offset register took a write");

	AST_RESET_REFCTL: assert property (@(posedge i_core_clk)
		$past(i_rst) |-> o_ana.vref == VREF_INT_HS &&
		!o_ana.temp_sensor_on && !o_ana.analog_ground_pin_sel)
		else $error("reference reset wrong");
endmodule // adcsel_ctl

// ===== tb/adcsel_far_model.sv
`timescale 1ns/1ps
module adcsel_far_model
	import adcsel_pkg::*;
	#(parameter logic [9:0] OFFSET = 10'h2a5)
(
	input wire adcsel_pkg::adcsel_ana_s i_ana,
	output logic [9:0] o_factory_temp_offset,
	output logic o_meas_ok
);
	// production measurement result, fixed for this part
	assign o_factory_temp_offset = OFFSET;
	// a sensor reading is usable only when routed, powered, not floating and
	// taken on the same reference as the production measurement
	assign o_meas_ok = i_ana.temp_route && i_ana.temp_sensor_on &&
		!i_ana.temp_hiz && (i_ana.vref == VREF_INT_HS);
endmodule // adcsel_far_model

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import adcsel_pkg::*;
	localparam logic [9:0] OFFV = 10'h2a5;
	logic i_core_clk = 1'b0;
	logic i_rst = 1'b1;
	adcsel_sfr_req_s i_sfr = '0;
	logic [9:0] off;
	logic [7:0] o_sfr_rdata;
	logic o_sfr_rvalid;
	adcsel_ana_s o_ana;
	logic meas_ok;
	logic [7:0] expq[$];
	int mismatches = 0;
	int n_compared = 0;
	always #2 i_core_clk = ~i_core_clk;
	adcsel_far_model #(.OFFSET(OFFV)) far (.i_ana(o_ana),
		.o_factory_temp_offset(off), .o_meas_ok(meas_ok));
	adcsel_ctl DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_sfr(i_sfr),
		.i_factory_temp_offset(off), .o_sfr_rdata(o_sfr_rdata),
		.o_sfr_rvalid(o_sfr_rvalid), .o_ana(o_ana));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] s, e);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic conclude();
		if (mismatches == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic op(input logic [7:0] pg, ad, input logic w, r,
		input logic [7:0] wd, ex);
		@(posedge i_core_clk);
		#1;
		i_sfr = '{pg, ad, w, r, wd};
		if (r)
			expq.push_back(ex);
	endtask
	function automatic logic [7:0] exp_src(input logic [4:0] c);
		if (c <= 5'h07 || (c >= 5'h0c && c <= 5'h13))
			return 8'(SRC_PORT);
		case (c)
			5'h1b: return 8'(SRC_TEMP);
			5'h1c, 5'h1e: return 8'(SRC_VBAT);
			5'h1d: return 8'(SRC_VREG);
			5'h1f: return 8'(SRC_GND);
			default: return 8'(SRC_NONE);
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////////
	always @(negedge i_core_clk) begin
		if (o_sfr_rvalid === 1'b1) begin
			if (expq.size() == 0)
				chk("rvalid", 8'h01, 8'h00);
			else
				chk("rdata", o_sfr_rdata, expq.pop_front());
		end
	end
	initial begin
		#20000;
		mismatches++;
		conclude();
	end
	initial begin
		logic [4:0] c;
		logic [7:0] r;
		logic [2:0] s;
		r = $urandom(93460);
		repeat (2) @(posedge i_core_clk);
		#1;
		i_rst = 1'b0;
		chk("src", 8'(o_ana.src), 8'(SRC_GND));
		chk("hiz", 8'(o_ana.temp_hiz), 8'h01);
		chk("vref", 8'(o_ana.vref), 8'h03);
		op(PAGE_MAIN, ADDR_CHSEL, 0, 1, 0, 8'h1f);
		op(PAGE_MAIN, ADDR_REFCTL, 0, 1, 0, 8'h18);
		op(PAGE_CAL, ADDR_FACTORY_TEMP_OFFSET_HI, 1, 1, 8'h00, OFFV[9:2]);
		op(PAGE_CAL, ADDR_FACTORY_TEMP_OFFSET_LO, 1, 1, 8'hff, {OFFV[1:0], 6'h00});
		op(PAGE_CAL, ADDR_FACTORY_TEMP_OFFSET_HI, 0, 1, 0, OFFV[9:2]);
		op(PAGE_CAL, ADDR_FACTORY_TEMP_OFFSET_LO, 0, 1, 0, {OFFV[1:0], 6'h00});
		op(PAGE_MAIN, ADDR_FACTORY_TEMP_OFFSET_HI, 0, 1, 0, 8'h00);
		op(PAGE_CAL, 8'hbc, 1, 1, 8'h5a, 8'h00);
		for (int i = 0; i < 32; i++) begin
			r = $urandom;
			c = i[4:0];
			op(PAGE_MAIN, ADDR_CHSEL, 1, 0, {r[7:5], c}, 0);
			op(PAGE_MAIN, ADDR_CHSEL, 0, 1, 0, {3'h0, c});
			chk("code", 8'(o_ana.positive_input_code), 8'(c));
			chk("src", 8'(o_ana.src), exp_src(c));
			if (exp_src(c) == 8'(SRC_PORT)) begin
				chk("port", 8'(o_ana.port), 8'(c[4] ? 2'h2 : {1'b0, c[3]}));
				chk("pin", 8'(o_ana.pin), 8'(c[2:0]));
			end
			chk("route", 8'(o_ana.temp_route), 8'(c == 5'h1b));
		end
		op(PAGE_MAIN, ADDR_CHSEL, 1, 0, 8'h1b, 0);
		for (int v = 0; v < 8; v++) begin
			r = $urandom;
			s = v[2:0];
			op(PAGE_MAIN, ADDR_REFCTL, 1, 0, {r[7:5], s, r[1:0]}, 0);
			op(PAGE_MAIN, ADDR_REFCTL, 0, 1, 0, {2'h0, r[5], s, 2'h0});
			chk("vref", 8'(o_ana.vref), 8'(s[2:1]));
			chk("analog_ground_pin", 8'(o_ana.analog_ground_pin_sel), 8'(r[5]));
			chk("analog_ground_pin_eff", 8'(o_ana.analog_ground_pin_effective), 8'h00);
			chk("hiz", 8'(o_ana.temp_hiz), 8'(!s[0]));
			chk("valid", 8'(o_ana.temp_data_valid), 8'(s[0]));
			chk("meas", 8'(meas_ok), 8'(s == 3'h7));
		end
		op(PAGE_MAIN, ADDR_CHSEL, 1, 1, 8'h03, 8'h1b);
		op(PAGE_MAIN, ADDR_CHSEL, 0, 0, 0, 0);
		chk("analog_ground_pin_eff", 8'(o_ana.analog_ground_pin_effective), 8'(r[5]));
		chk("route", 8'(o_ana.temp_route), 8'h00);
		repeat (3) @(posedge i_core_clk);
		chk("pending", 8'(expq.size()), 8'h00);
		conclude();
	end
endmodule // tb_top
